// ===== logic/alc_top.sv
`timescale 1ns/1ns
// How it works
// RL1: Gain loop raises gain when dark, up to ceiling
// RL2: Gain loop lowers gain when bright, down to floor
// RL3: Software selects analog channel before enabling gain loop
// RL4: Manual analog gain writes ignored while loop runs
// RL5: Manual analog 0..148, digital 0..255, reset 0
// RL6: Gain loop enable input, off after reset
// RL7: Gain floor 0..148, reset 0, refused above ceiling
// RL8: Gain ceiling 0..148, reset 148
// RL9: Shutter loop lengthens exposure when dark, up to ceiling
// RL10: Shutter loop shortens exposure when bright, to floor
// RL11: Shutter loop enable input, off after reset
// RL12: Exposure floor in us, 8..16777215, reset 8
// RL13: Exposure ceiling in us, 8..16777215, reset 4029
// RL14: Software sets zones, gain, shutter, then goal
// RL15: Exposure corrects first; gain only when exposure pinned
// RL16: Per-zone average and peak, weighted into brightness
// RL17: Blend ratio mixes average and peak linearly
// RL18: Goal scaled x16, x4 or x1 by depth
// RL19: One adjustment per frame, effective next frame
module alc_top (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_frame_start,
    input wire logic i_frame_end,
    input wire logic i_pix_valid,
    input wire logic [9:0] i_pix_x,
    input wire logic [9:0] i_pix_y,
    input wire logic [11:0] i_pix_data,
    input wire logic [1:0] i_out_depth,
    input wire logic i_cfg_wr,
    input wire logic [3:0] i_zone_index,
    input wire logic [9:0] i_zone_width,
    input wire logic [9:0] i_zone_height,
    input wire logic [9:0] i_zone_x,
    input wire logic [9:0] i_zone_y,
    input wire logic [3:0] i_zone_weight,
    input wire logic [7:0] i_peak_blend_ratio,
    input wire logic [7:0] i_brightness_goal,
    input wire logic i_gain_channel_select,
    input wire logic i_gain_wr,
    input wire logic [7:0] i_gain_value,
    input wire logic i_gain_loop_enable,
    input wire logic [7:0] i_gain_loop_floor,
    input wire logic [7:0] i_gain_loop_ceiling,
    input wire logic i_shutter_loop_enable,
    input wire logic [23:0] i_shutter_loop_floor,
    input wire logic [23:0] i_shutter_loop_ceiling,
    input wire logic [23:0] i_manual_exposure,
    output logic [7:0] o_analog_gain,
    output logic [7:0] o_digital_gain,
    output logic [23:0] o_exposure_us,
    output logic [7:0] o_gain_floor,
    output logic [7:0] o_gain_ceiling,
    output logic [23:0] o_shutter_floor,
    output logic [23:0] o_shutter_ceiling,
    output logic [31:0] o_brightness,
    output logic o_adjust_done
);
    // Zone geometry and weight tables, written through the config strobe
    logic [9:0] zx_r [alc_pkg::ZONES];
    logic [9:0] zy_r [alc_pkg::ZONES];
    logic [9:0] zw_r [alc_pkg::ZONES];
    logic [9:0] zh_r [alc_pkg::ZONES];
    logic [3:0] zwt_r [alc_pkg::ZONES];
    // Per-zone running statistics for the current frame
    logic [31:0] acc_sum_r [alc_pkg::ZONES], acc_sum_nxt [alc_pkg::ZONES];
    logic [11:0] acc_pk_r [alc_pkg::ZONES], acc_pk_nxt [alc_pkg::ZONES];
    logic [19:0] cnt_r [alc_pkg::ZONES], cnt_nxt [alc_pkg::ZONES];
    // Loop state
    alc_pkg::alc_phase_t ph_r, ph_nxt; // Phase of the per-frame evaluation
    logic [3:0] idx_r, idx_nxt; // Zone walked in the mix phase
    logic [39:0] wsum_r, wsum_nxt; // Weighted blended brightness sum
    logic [7:0] wtot_r, wtot_nxt; // Total of weights
    logic [7:0] ag_r, ag_nxt; // Analog gain
    logic [7:0] dg_r, dg_nxt; // Digital gain
    logic [23:0] ex_r, ex_nxt; // Exposure in us
    logic [7:0] gf_r, gf_nxt; // Gain floor
    logic [7:0] gc_r, gc_nxt; // Gain ceiling
    logic [23:0] sf_r, sf_nxt; // Shutter floor
    logic [23:0] sc_r, sc_nxt; // Shutter ceiling
    logic [31:0] br_r, br_nxt; // Measured brightness
    logic done_r, done_nxt; // Adjustment pulse

    // Inside-zone test, used by every zone
    function automatic logic in_zone(input logic [9:0] px, input logic [9:0] py,
        input logic [9:0] x0, input logic [9:0] y0, input logic [9:0] w, input logic [9:0] h);
        in_zone = ({1'b0, px} >= {1'b0, x0}) && ({1'b0, px} < 11'(x0 + w))
            && ({1'b0, py} >= {1'b0, y0}) && ({1'b0, py} < 11'(y0 + h));
    endfunction

    // Linear blend of average and peak by ratio over full scale
    function automatic logic [31:0] blend(input logic [31:0] avg, input logic [11:0] pk,
        input logic [7:0] r);
        logic [39:0] t;
        t = 40'(avg) * 40'(alc_pkg::BLEND_FULL - r) + 40'(pk) * 40'(r);
        blend = 32'(t / 40'(alc_pkg::BLEND_FULL));
    endfunction

    // Zone table writes; defaults are a neutral unit weight
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
        begin
            for (int k = 0; k < alc_pkg::ZONES; k++)
            begin
                zx_r[k] <= '0;
                zy_r[k] <= '0;
                zw_r[k] <= '0;
                zh_r[k] <= '0;
                zwt_r[k] <= 4'h1;
            end
        end
        else if (i_cfg_wr && i_zone_index < 4'(alc_pkg::ZONES))
        begin
            zx_r[i_zone_index] <= i_zone_x;
            zy_r[i_zone_index] <= i_zone_y;
            zw_r[i_zone_index] <= i_zone_width;
            zh_r[i_zone_index] <= i_zone_height;
            zwt_r[i_zone_index] <= i_zone_weight;
        end
    end

    // Pixel statistics: sum, count and peak per zone over one frame
    always_comb
    begin
        for (int k = 0; k < alc_pkg::ZONES; k++)
        begin
            acc_sum_nxt[k] = acc_sum_r[k];
            acc_pk_nxt[k] = acc_pk_r[k];
            cnt_nxt[k] = cnt_r[k];
            if (i_frame_start)
            begin
                acc_sum_nxt[k] = '0;
                acc_pk_nxt[k] = '0;
                cnt_nxt[k] = '0;
            end
            else if (i_pix_valid && in_zone(i_pix_x, i_pix_y, zx_r[k], zy_r[k], zw_r[k], zh_r[k]))
            begin
                acc_sum_nxt[k] = acc_sum_r[k] + 32'(i_pix_data); // RL16
                cnt_nxt[k] = cnt_r[k] + 20'h1;
                if (i_pix_data > acc_pk_r[k])
                    acc_pk_nxt[k] = i_pix_data; // RL16
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        for (int k = 0; k < alc_pkg::ZONES; k++)
        begin
            if (!i_rst_b)
            begin
                acc_sum_r[k] <= '0;
                acc_pk_r[k] <= '0;
                cnt_r[k] <= '0;
            end
            else
            begin
                acc_sum_r[k] <= acc_sum_nxt[k];
                acc_pk_r[k] <= acc_pk_nxt[k];
                cnt_r[k] <= cnt_nxt[k];
            end
        end
    end

    // Frame-end snapshot store, walked one zone a cycle after the frame
    alc_zone_if zp ();
    alc_zone_mem u_mem (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .zp(zp.store)
    );
    logic [3:0] snap_r, snap_nxt; // Zone being snapshotted
    logic [31:0] avg_w; // Average of zone being written
    assign avg_w = (cnt_r[snap_r] == '0) ? '0 : acc_sum_r[snap_r] / 32'(cnt_r[snap_r]);
    assign zp.clr = i_frame_start;
    assign zp.wr = (ph_r == alc_pkg::ALC_SCAN);
    assign zp.wr_idx = snap_r;
    assign zp.wr_sum = avg_w;
    assign zp.wr_peak = acc_pk_r[snap_r];
    assign zp.rd_idx = idx_r;

    // Goal scaled to the output depth
    logic [31:0] goal_w;
    always_comb
    begin
        unique case (i_out_depth)
            alc_pkg::DEPTH_12: goal_w = 32'(i_brightness_goal) << alc_pkg::SHIFT_12; // RL18
            alc_pkg::DEPTH_10: goal_w = 32'(i_brightness_goal) << alc_pkg::SHIFT_10; // RL18
            default: goal_w = 32'(i_brightness_goal); // RL18
        endcase
    end

    // Loop next-state: config capture, evaluation phases and one adjustment per frame
    always_comb
    begin
        logic dark;
        logic bright;
        logic ex_pinned_hi;
        logic ex_pinned_lo;
        dark = 1'b0;
        bright = 1'b0;
        ex_pinned_hi = 1'b0;
        ex_pinned_lo = 1'b0;
        ph_nxt = ph_r;
        idx_nxt = idx_r;
        snap_nxt = snap_r;
        wsum_nxt = wsum_r;
        wtot_nxt = wtot_r;
        ag_nxt = ag_r;
        dg_nxt = dg_r;
        ex_nxt = ex_r;
        gf_nxt = gf_r;
        gc_nxt = gc_r;
        sf_nxt = sf_r;
        sc_nxt = sc_r;
        br_nxt = br_r;
        done_nxt = 1'b0;
        // Limits: out-of-range refused; gain floor is held against the new gain ceiling so those never cross; shutter limits are not ordered
        if (i_gain_loop_ceiling <= alc_pkg::ANALOG_GAIN_MAX && i_gain_loop_ceiling >= gf_r)
            gc_nxt = i_gain_loop_ceiling; // RL8
        if (i_gain_loop_floor <= alc_pkg::ANALOG_GAIN_MAX && i_gain_loop_floor <= gc_nxt)
            gf_nxt = i_gain_loop_floor; // RL7
        if (i_shutter_loop_floor >= alc_pkg::EXP_MIN_LEGAL)
            sf_nxt = i_shutter_loop_floor; // RL12
        if (i_shutter_loop_ceiling >= alc_pkg::EXP_MIN_LEGAL)
            sc_nxt = i_shutter_loop_ceiling; // RL13
        // Manual gain writes; analog blocked while the gain loop runs
        if (i_gain_wr)
        begin
            if (i_gain_channel_select == alc_pkg::CH_DIGITAL)
                dg_nxt = i_gain_value; // RL5
            else if (!i_gain_loop_enable && i_gain_value <= alc_pkg::ANALOG_GAIN_MAX)
                ag_nxt = i_gain_value; // RL4 RL5
        end
        // Manual exposure applies only while the shutter loop is off
        if (!i_shutter_loop_enable && i_manual_exposure >= alc_pkg::EXP_MIN_LEGAL)
            ex_nxt = i_manual_exposure;
        unique case (ph_r)
            alc_pkg::ALC_IDLE:
            begin
                if (i_frame_end)
                begin
                    ph_nxt = alc_pkg::ALC_SCAN; // RL19
                    snap_nxt = '0;
                end
            end
            alc_pkg::ALC_SCAN:
            begin
                snap_nxt = snap_r + 4'h1;
                if (snap_r == 4'(alc_pkg::ZONES - 1))
                begin
                    ph_nxt = alc_pkg::ALC_MIX;
                    idx_nxt = '0;
                    wsum_nxt = '0;
                    wtot_nxt = '0;
                end
            end
            alc_pkg::ALC_MIX:
            begin
                // Read data lags the index by one cycle, so accumulate the previous zone
                idx_nxt = idx_r + 4'h1;
                if (idx_r != '0)
                begin
                    wsum_nxt = wsum_r + 40'(blend(zp.rd_sum, zp.rd_peak, i_peak_blend_ratio))
                        * 40'(zwt_r[idx_r - 4'h1]); // RL16 RL17
                    wtot_nxt = wtot_r + 8'(zwt_r[idx_r - 4'h1]);
                end
                if (idx_r == 4'(alc_pkg::ZONES))
                    ph_nxt = alc_pkg::ALC_ADJUST;
            end
            alc_pkg::ALC_ADJUST:
            begin
                br_nxt = (wtot_r == '0) ? '0 : 32'(wsum_r / 40'(wtot_r)); // RL16
                dark = br_nxt < goal_w;
                bright = br_nxt > goal_w;
                ex_pinned_hi = !i_shutter_loop_enable || ex_r >= sc_r;
                ex_pinned_lo = !i_shutter_loop_enable || ex_r <= sf_r;
                // Exposure moves first, gain only once exposure is at its limit or the shutter loop is off
                if (i_shutter_loop_enable && dark && ex_r < sc_r)
                    ex_nxt = ex_r + alc_pkg::EXP_STEP; // RL9 RL11 RL15
                else if (i_shutter_loop_enable && bright && ex_r > sf_r)
                    ex_nxt = ex_r - alc_pkg::EXP_STEP; // RL10 RL11 RL15
                else if (i_gain_loop_enable && dark && ex_pinned_hi && ag_r < gc_r)
                    ag_nxt = ag_r + alc_pkg::GAIN_STEP; // RL1 RL6 RL15
                else if (i_gain_loop_enable && bright && ex_pinned_lo && ag_r > gf_r)
                    ag_nxt = ag_r - alc_pkg::GAIN_STEP; // RL2 RL6 RL15
                done_nxt = 1'b1; // RL19
                ph_nxt = alc_pkg::ALC_IDLE;
            end
        endcase
    end

    // Loop registers
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b)
        begin
            ph_r <= alc_pkg::ALC_IDLE;
            idx_r <= '0;
            snap_r <= '0;
            wsum_r <= '0;
            wtot_r <= '0;
            ag_r <= alc_pkg::ANALOG_GAIN_RST; // RL5
            dg_r <= alc_pkg::DIGITAL_GAIN_RST; // RL5
            ex_r <= alc_pkg::EXP_CEIL_RST;
            gf_r <= alc_pkg::GAIN_FLOOR_RST; // RL7
            gc_r <= alc_pkg::GAIN_CEIL_RST; // RL8
            sf_r <= alc_pkg::EXP_FLOOR_RST; // RL12
            sc_r <= alc_pkg::EXP_CEIL_RST; // RL13
            br_r <= '0;
            done_r <= 1'b0;
        end
        else
        begin
            ph_r <= ph_nxt;
            idx_r <= idx_nxt;
            snap_r <= snap_nxt;
            wsum_r <= wsum_nxt;
            wtot_r <= wtot_nxt;
            ag_r <= ag_nxt;
            dg_r <= dg_nxt;
            ex_r <= ex_nxt;
            gf_r <= gf_nxt;
            gc_r <= gc_nxt;
            sf_r <= sf_nxt;
            sc_r <= sc_nxt;
            br_r <= br_nxt;
            done_r <= done_nxt;
        end
    end

    // Outputs, all from flip-flops
    assign o_analog_gain = ag_r;
    assign o_digital_gain = dg_r;
    assign o_exposure_us = ex_r;
    assign o_gain_floor = gf_r;
    assign o_gain_ceiling = gc_r;
    assign o_shutter_floor = sf_r;
    assign o_shutter_ceiling = sc_r;
    assign o_brightness = br_r;
    assign o_adjust_done = done_r;
endmodule

// ===== common/alc_pkg.sv
package alc_pkg;
    // Gain code ranges
    localparam int GAIN_W = 8;
    localparam logic [7:0] ANALOG_GAIN_MAX = 8'h94;
    localparam logic [7:0] ANALOG_GAIN_RST = 8'h00;
    localparam logic [7:0] DIGITAL_GAIN_RST = 8'h00;
    localparam logic [7:0] GAIN_FLOOR_RST = 8'h00;
    localparam logic [7:0] GAIN_CEIL_RST = 8'h94;
    localparam logic [7:0] GAIN_STEP = 8'h01;
    // Exposure limits in microseconds
    localparam int EXP_W = 24;
    localparam logic [23:0] EXP_MIN_LEGAL = 24'h000008;
    localparam logic [23:0] EXP_MAX_LEGAL = 24'hffffff;
    localparam logic [23:0] EXP_FLOOR_RST = 24'h000008;
    localparam logic [23:0] EXP_CEIL_RST = 24'h000fbd;
    localparam logic [23:0] EXP_STEP = 24'h000001;
    // Brightness and metering
    localparam int PIX_W = 12;
    localparam int ZONES = 9;
    localparam int ZONE_IDX_W = 4;
    localparam int COORD_W = 10;
    localparam int WEIGHT_W = 4;
    localparam int ACC_W = 32;
    localparam int WSUM_W = 8;
    localparam logic [7:0] BLEND_FULL = 8'hff;
    // Output depth codes and target scaling shifts
    localparam logic [1:0] DEPTH_8 = 2'h0;
    localparam logic [1:0] DEPTH_10 = 2'h1;
    localparam logic [1:0] DEPTH_12 = 2'h2;
    localparam int SHIFT_10 = 2;
    localparam int SHIFT_12 = 4;
    // Gain channel codes
    localparam logic CH_ANALOG = 1'b0;
    localparam logic CH_DIGITAL = 1'b1;
    // Loop phases
    typedef enum logic [1:0] {ALC_IDLE, ALC_SCAN, ALC_MIX, ALC_ADJUST} alc_phase_t;
endpackage

// ===== common/alc_zone_if.sv
`timescale 1ns/1ns
// Carries the per-zone statistics between the top and the zone store
interface alc_zone_if;
    logic clr;
    logic wr;
    logic [3:0] wr_idx;
    logic [31:0] wr_sum;
    logic [11:0] wr_peak;
    logic [3:0] rd_idx;
    logic [31:0] rd_sum;
    logic [11:0] rd_peak;
    modport store (input clr, input wr, input wr_idx, input wr_sum, input wr_peak,
        input rd_idx, output rd_sum, output rd_peak);
    modport user (output clr, output wr, output wr_idx, output wr_sum, output wr_peak,
        output rd_idx, input rd_sum, input rd_peak);
endinterface

// ===== logic/alc_zone_mem.sv
`timescale 1ns/1ns
// Small store of per-zone average and peak; read data comes out of a register
module alc_zone_mem (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    alc_zone_if.store zp
);
    logic [31:0] sum_mem [alc_pkg::ZONES]; // Per-zone pixel averages
    logic [11:0] peak_mem [alc_pkg::ZONES]; // Per-zone peaks
    logic [31:0] rd_sum_r; // Registered read sum
    logic [11:0] rd_peak_r; // Registered read peak

    // Memory write and registered read; clear empties all zones at frame start
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_b || zp.clr)
        begin
            for (int k = 0; k < alc_pkg::ZONES; k++)
            begin
                sum_mem[k] <= '0;
                peak_mem[k] <= '0;
            end
            rd_sum_r <= '0;
            rd_peak_r <= '0;
        end
        else
        begin
            if (zp.wr && zp.wr_idx < 4'(alc_pkg::ZONES))
            begin
                sum_mem[zp.wr_idx] <= zp.wr_sum;
                peak_mem[zp.wr_idx] <= zp.wr_peak;
            end
            if (zp.rd_idx < 4'(alc_pkg::ZONES))
            begin
                rd_sum_r <= sum_mem[zp.rd_idx];
                rd_peak_r <= peak_mem[zp.rd_idx];
            end
            else
            begin
                rd_sum_r <= '0;
                rd_peak_r <= '0;
            end
        end
    end

    assign zp.rd_sum = rd_sum_r;
    assign zp.rd_peak = rd_peak_r;
endmodule

// ===== verification/alc_top_props.sv
`timescale 1ns/1ns
// Watches the loop outputs of the light control top at its ports
module alc_top_props (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_gain_wr,
    input wire logic i_gain_channel_select,
    input wire logic i_gain_loop_enable,
    input wire logic i_shutter_loop_enable,
    input wire logic [7:0] o_analog_gain,
    input wire logic [23:0] o_exposure_us,
    input wire logic [7:0] o_gain_floor,
    input wire logic [7:0] o_gain_ceiling,
    input wire logic [23:0] o_shutter_floor,
    input wire logic [23:0] o_shutter_ceiling,
    input wire logic o_adjust_done
);
    // One clock domain, so one clocking and one reset for all properties
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);

    a_gain_rise_step:
    assert property (o_adjust_done && o_analog_gain > $past(o_analog_gain) |->
        o_analog_gain == $past(o_analog_gain) + 8'h01 && o_analog_gain <= o_gain_ceiling)
        else $error("gain rose by more than one code or past its ceiling");
    a_gain_fall_step:
    assert property (o_adjust_done && o_analog_gain < $past(o_analog_gain) |->
        o_analog_gain == $past(o_analog_gain) - 8'h01 && o_analog_gain >= o_gain_floor)
        else $error("gain fell by more than one code or under its floor");
    a_manual_gain_locked:
    assert property (i_gain_wr && i_gain_loop_enable && i_gain_channel_select == alc_pkg::CH_ANALOG
        |=> o_adjust_done || o_analog_gain == $past(o_analog_gain))
        else $error("manual analog write took effect while gain loop ran");
    a_analog_in_range:
    assert property (o_analog_gain <= alc_pkg::ANALOG_GAIN_MAX)
        else $error("analog gain above its top code");
    a_gain_limit_order:
    assert property (o_gain_floor <= o_gain_ceiling && o_gain_ceiling <= 8'h94)
        else $error("accepted gain limits out of order or range");
    a_exp_rise_step:
    assert property (o_adjust_done && i_shutter_loop_enable && o_exposure_us > $past(o_exposure_us)
        |-> o_exposure_us == $past(o_exposure_us) + 24'h1 && o_exposure_us <= o_shutter_ceiling)
        else $error("exposure rose by more than one step or past its ceiling");
    a_exp_fall_step:
    assert property (o_adjust_done && i_shutter_loop_enable && o_exposure_us < $past(o_exposure_us)
        |-> o_exposure_us == $past(o_exposure_us) - 24'h000001 && o_exposure_us >= o_shutter_floor)
        else $error("exposure fell by more than one step or under its floor");
    a_exp_limits_legal:
    assert property (o_shutter_floor >= 24'h000008 && o_shutter_ceiling >= 24'h000008)
        else $error("accepted exposure limit below eight");
    a_shutter_goes_first:
    assert property (o_adjust_done && i_shutter_loop_enable && !$stable(o_analog_gain)
        |-> $stable(o_exposure_us)
        && (o_exposure_us >= o_shutter_ceiling || o_exposure_us <= o_shutter_floor))
        else $error("gain moved while exposure still had room");
    a_done_single:
    assert property (o_adjust_done |=> !o_adjust_done [*8])
        else $error("adjustment pulse repeated too soon");
endmodule

// ===== verification/alc_sensor_model.sv
`timescale 1ns/1ns
// Stand-in sensor: one row of eight pixels per frame, prompt or with gaps
module alc_sensor_model (
    input wire logic i_clk_sys,
    output logic o_frame_start,
    output logic o_frame_end,
    output logic o_pix_valid,
    output logic [9:0] o_pix_x,
    output logic [11:0] o_pix_data
);
    // Idle lines at time zero
    initial
    begin
        {o_frame_start, o_frame_end, o_pix_valid} = 3'h0;
        o_pix_x = 10'h000;
        o_pix_data = 12'h000;
    end

    // Slow mode idles a cycle per pixel; idle data is inverted so nothing stale looks valid
    task automatic send_frame(input logic [7:0][11:0] row, input bit slow);
        @(posedge i_clk_sys) #1 o_frame_start = 1'b1;
        @(posedge i_clk_sys) #1 o_frame_start = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            o_pix_valid = 1'b1;
            o_pix_x = 10'(i);
            o_pix_data = row[i];
            @(posedge i_clk_sys) #1;
            if (slow)
            begin
                o_pix_valid = 1'b0;
                o_pix_data = ~row[i];
                @(posedge i_clk_sys) #1;
            end
        end
        o_pix_valid = 1'b0;
        o_pix_data = ~row[7];
        o_frame_end = 1'b1;
        @(posedge i_clk_sys) #1 o_frame_end = 1'b0;
    endtask
endmodule

// ===== verification/alc_top_tb.sv
`timescale 1ns/1ns
module alc_top_tb;
    logic clk, rst_b, fs, fe, pv, cfg_wr, gsel, gwr, gen, sen, done;
    logic [9:0] px, zx, zw;
    logic [11:0] pd;
    logic [1:0] depth;
    logic [3:0] zidx, zwt;
    logic [7:0] ratio, goal, gval, gfl, gce, ag, dg, gfo, gco;
    logic [23:0] sfl, sce, mexp, exp_us, sfo, sco;
    logic [31:0] bright;
    logic [7:0][11:0] row; // Pixel row for the next frame
    int fails, samples_checked, m_exp, m_gain, w0, w1; // Bench-side loop state

    alc_sensor_model u_sensor (.i_clk_sys(clk), .o_frame_start(fs), .o_frame_end(fe),
        .o_pix_valid(pv), .o_pix_x(px), .o_pix_data(pd));
    // Only one row and zone height one are used, so y inputs stay fixed
    alc_top DUT (.i_clk_sys(clk), .i_rst_b(rst_b), .i_frame_start(fs), .i_frame_end(fe),
        .i_pix_valid(pv), .i_pix_x(px), .i_pix_y(10'h000), .i_pix_data(pd), .i_out_depth(depth),
        .i_cfg_wr(cfg_wr), .i_zone_index(zidx), .i_zone_width(zw), .i_zone_height(10'h001),
        .i_zone_x(zx), .i_zone_y(10'h000), .i_zone_weight(zwt), .i_peak_blend_ratio(ratio),
        .i_brightness_goal(goal), .i_gain_channel_select(gsel), .i_gain_wr(gwr),
        .i_gain_value(gval), .i_gain_loop_enable(gen), .i_gain_loop_floor(gfl),
        .i_gain_loop_ceiling(gce), .i_shutter_loop_enable(sen), .i_shutter_loop_floor(sfl),
        .i_shutter_loop_ceiling(sce), .i_manual_exposure(mexp), .o_analog_gain(ag),
        .o_digital_gain(dg), .o_exposure_us(exp_us), .o_gain_floor(gfo), .o_gain_ceiling(gco),
        .o_shutter_floor(sfo), .o_shutter_ceiling(sco), .o_brightness(bright),
        .o_adjust_done(done));

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t %s: got %0h want %0h", $time, what, seen, exp);
        end
    endtask

    task automatic finish_test;
        if (fails == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Inputs always move 1 ns after an edge
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic gain_write(input logic ch, input logic [7:0] v);
        {gsel, gval, gwr} = {ch, v, 1'b1};
        cyc(1);
        gwr = 1'b0;
        cyc(1);
    endtask

    // Weight zero zones get no area so they never collect pixels
    task automatic zone(input int i, input int x, input int wt);
        {zidx, zx, zwt, cfg_wr} = {4'(i), 10'(x), 4'(wt), 1'b1};
        zw = (wt == 0) ? 10'h000 : 10'h004;
        cyc(1);
        cfg_wr = 1'b0;
        cyc(1);
    endtask

    task automatic lim_chk(input logic [7:0] f, c, input logic [23:0] sf, sc);
        cyc(2);
        check(gfo, f, "gain floor");
        check(gco, c, "gain ceiling");
        check(sfo, sf, "shutter floor");
        check(sco, sc, "shutter ceiling");
    endtask

    // Blend of one four-pixel zone; the average truncates like integer hardware
    function automatic int zone_val(input logic [7:0][11:0] r, input int lo, input int k);
        int s, pk;
        s = 0;
        pk = 0;
        for (int i = lo; i < lo + 4; i++)
        begin
            s += r[i];
            pk = (r[i] > pk) ? r[i] : pk;
        end
        return ((s / 4) * (255 - k) + pk * k) / 255;
    endfunction

    function automatic int goal_scaled(input int g, input logic [1:0] d);
        return (d == alc_pkg::DEPTH_12) ? g * 16 : (d == alc_pkg::DEPTH_10) ? g * 4 : g;
    endfunction

    // Predict one adjustment, run the frame, then compare at the done pulse
    task automatic run_frame(input logic [7:0][11:0] r, input bit slow);
        int b, t, n;
        b = (w0 * zone_val(r, 0, ratio) + w1 * zone_val(r, 4, ratio)) / (w0 + w1);
        t = goal_scaled(goal, depth);
        if (sen && b < t && m_exp < sce) m_exp++;
        else if (sen && b > t && m_exp > sfl) m_exp--;
        else if (gen && b < t && m_gain < gce) m_gain++;
        else if (gen && b > t && m_gain > gfl) m_gain--;
        if (!sen) m_exp = mexp;
        u_sensor.send_frame(r, slow);
        n = 0;
        while (done !== 1'b1 && n < 40)
        begin
            cyc(1);
            n++;
        end
        check(n, 20, "adjust latency");
        check(bright, b, "brightness");
        check(exp_us, m_exp, "exposure");
        check(ag, m_gain, "analog gain");
    endtask

    initial
    begin
        {rst_b, cfg_wr, gsel, gwr, gen, sen, depth, zidx, zwt, zx, zw} = '0;
        {ratio, goal, gval, mexp} = {24'h0, 24'h000fbd};
        {gfl, gce, sfl, sce} = {8'h05, 8'h20, 24'h000010, 24'h000100};
        void'($urandom(51039));
        cyc(4);
        // Reset values win over the limit inputs while reset is held
        check(ag, 8'h00, "reset analog");
        check(dg, 8'h00, "reset digital");
        check(exp_us, 24'h000fbd, "reset exposure");
        lim_chk(8'h00, 8'h94, 24'h000008, 24'h000fbd);
        rst_b = 1'b1;
        lim_chk(8'h05, 8'h20, 24'h000010, 24'h000100);
        // Floor above ceiling and exposure limits under eight are refused
        {gfl, sfl, sce} = {8'h21, 24'h000007, 24'h000007};
        lim_chk(8'h05, 8'h20, 24'h000010, 24'h000100);
        {gfl, gce} = {8'h03, 8'h95};
        lim_chk(8'h03, 8'h20, 24'h000010, 24'h000100);
        gce = 8'h02;
        lim_chk(8'h03, 8'h20, 24'h000010, 24'h000100);
        {gce, sfl, sce} = {8'h0a, 24'h000fb4, 24'h000fbd};
        lim_chk(8'h03, 8'h0a, 24'h000fb4, 24'h000fbd);
        gain_write(alc_pkg::CH_ANALOG, 8'h94);
        check(ag, 8'h94, "analog top");
        gain_write(alc_pkg::CH_ANALOG, 8'h95);
        check(ag, 8'h94, "analog over");
        gain_write(alc_pkg::CH_DIGITAL, 8'hff);
        check(dg, 8'hff, "digital top");
        {w0, w1} = {32'($urandom_range(15, 1)), 32'($urandom_range(15, 1))};
        zone(0, 0, w0);
        zone(1, 4, w1);
        for (int i = 2; i < 9; i++) zone(i, 0, 0);
        gain_write(alc_pkg::CH_ANALOG, 8'h05);
        {m_gain, m_exp} = {32'h5, 32'hfbd};
        {gen, sen, goal, ratio} = {1'b1, 1'b1, 8'hff, 8'($urandom)};
        // Dark: exposure pinned at ceiling so gain climbs to its ceiling and stays
        repeat (8) run_frame('0, 1'b0);
        goal = 8'h00;
        // Bright: exposure down to floor first, then gain down to floor
        repeat (18) run_frame({8{12'hfff}}, 1'b1);
        gain_write(alc_pkg::CH_ANALOG, 8'h40);
        check(ag, m_gain, "locked analog");
        mexp = 24'h000fb9;
        for (int i = 0; i < 30; i++)
        begin
            foreach (row[k]) row[k] = 12'($urandom_range(4095) >> $urandom_range(3));
            ratio = (i < 2) ? {8{i[0]}} : 8'($urandom);
            {goal, depth, gen, sen} = {8'($urandom), 2'(i % 3), 2'($urandom)};
            run_frame(row, 1'($urandom));
        end
        finish_test();
    end

    // Whole run needs a few thousand cycles
    initial
    begin
        #100000;
        fails++;
        finish_test();
    end
endmodule

bind alc_top alc_top_props u_props (.i_clk_sys, .i_rst_b, .i_gain_wr, .i_gain_channel_select,
    .i_gain_loop_enable, .i_shutter_loop_enable, .o_analog_gain, .o_exposure_us, .o_gain_floor,
    .o_gain_ceiling, .o_shutter_floor, .o_shutter_ceiling, .o_adjust_done);
